// file: bench/aes_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module aes_mem_model (
	input wire logic                     clk,
	input wire logic [3:0]               waitCycles,
	input wire aes_pkg::aes_bus_req_type busReq,
	output var aes_pkg::aes_bus_rsp_type busRsp
);
	import aes_pkg::*;
	logic [3:0]  cnt = 4'h0;
	logic [31:0] wa[2];
	logic [31:0] wd[2];
	initial busRsp = '0;
	// idle data flips each cycle so a stale value never passes as valid
	always @(posedge clk) begin
		busRsp <= '{1'b0, ~busRsp.rdata};
		cnt <= (busReq.req && !busRsp.ack) ? cnt + 4'h1 : 4'h0;
		if (busReq.req && !busRsp.ack && cnt >= waitCycles) begin
			busRsp <= '{1'b1, busReq.write ? ~busRsp.rdata : 32'h0000_1230};
			if (busReq.write) begin
				wa <= '{wa[1], busReq.addr};
				wd <= '{wd[1], busReq.wdata};
			end
		end
	end
endmodule // aes_mem_model
`default_nettype wire

// file: bench/aes_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "aes_params.svh"
module aes_seq_monitor (
	input wire logic                       clk,
	input wire logic                       arst_n,
	input wire logic                       addrError,
	input wire logic                       instrDone,
	input wire aes_pkg::aes_cpu_state_type cpuState,
	input wire aes_pkg::aes_bus_rsp_type   busRsp,
	input wire aes_pkg::aes_bus_req_type   busReq,
	input wire logic                       abortCycle,
	input wire logic                       stallPipe,
	input wire logic                       jumpValid,
	input wire logic                       killDelaySlot,
	input wire logic [31:0]                jumpTarget,
	input wire logic [31:0]                newStackPointer,
	input wire logic                       busy
);
	import aes_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// high from the abort pulse until the instruction retires
	logic drainQ;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) drainQ <= 1'b0;
		else if (instrDone) drainQ <= 1'b0;
		else if (abortCycle) drainQ <= 1'b1;
	end
	logic [31:0] rdQ;
	wire logic rdAck = busReq.req && !busReq.write && busRsp.ack;
	wire logic wrAck = busReq.req && busReq.write && busRsp.ack;
	wire logic [31:0] sp = cpuState.stackPointer;
	always_ff @(posedge clk) if (rdAck) rdQ <= busRsp.rdata;
	a_abort_once: assert property (addrError && !busy |=> abortCycle ##1 !abortCycle)
		else $error("abort pulse wrong");
	a_wait_instr: assert property ((abortCycle || drainQ) |-> !busReq.req)
		else $error("bus used before retire");
	a_stall_bus: assert property (busReq.req |-> stallPipe)
		else $error("pipe not stalled during push");
	a_push_status: assert property (instrDone && busy |-> ##[1:3] (busReq.req
		&& busReq.write && busReq.addr == sp - 32'h4 && busReq.wdata == cpuState.statusWord))
		else $error("status push wrong");
	a_push_return: assert property (wrAck && busReq.addr == sp - 32'h4 |-> ##[1:4]
		(busReq.req && busReq.write && busReq.addr == sp - 32'h8
		&& busReq.wdata == cpuState.nextPointer)) else $error("return push wrong");
	a_vector_read: assert property (wrAck && busReq.addr == sp - 32'h8 |-> ##[1:4]
		(busReq.req && !busReq.write && busReq.addr == cpuState.vectorBase + `AES_VEC_ADDR_ERR))
		else $error("vector read wrong");
	a_jump_target: assert property (jumpValid |-> jumpTarget == rdQ)
		else $error("jump target wrong");
	a_no_slot: assert property (rdAck |-> ##[1:3] (jumpValid && killDelaySlot) ##1 !jumpValid)
		else $error("jump late or slot kept");
	a_stack_adj: assert property (jumpValid |-> newStackPointer == sp - 32'h8)
		else $error("stack pointer wrong");
	c_jump: cover property (jumpValid);
	c_refused: cover property (addrError && busy);
	c_write: cover property (wrAck);
endmodule // aes_seq_monitor
bind aes_seq aes_seq_monitor u_mon (.clk, .arst_n, .addrError, .instrDone, .cpuState, .busRsp,
	.busReq, .abortCycle, .stallPipe, .jumpValid, .killDelaySlot, .jumpTarget,
	.newStackPointer, .busy);
`default_nettype wire

// file: bench/aes_seq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module aes_seq_tb_top;
	import aes_pkg::*;
`define CHK(n, e, s) begin samplesChecked++; if ((s) !== (e)) begin errCount++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
	logic clk, arst_n, addrError, instrDone, abortCycle, stallPipe, jumpValid, killDelaySlot, busy;
	logic [3:0] waitCycles;
	logic [31:0] jumpTarget, newSp;
	aes_cpu_state_type cpuState;
	aes_bus_rsp_type busRsp;
	aes_bus_req_type busReq;
	int errCount = 0, samplesChecked = 0;
	aes_seq u_dut (.clk(clk), .arst_n(arst_n), .addrError(addrError), .instrDone(instrDone),
		.cpuState(cpuState), .busRsp(busRsp), .busReq(busReq), .abortCycle(abortCycle),
		.stallPipe(stallPipe),
		.jumpValid(jumpValid), .killDelaySlot(killDelaySlot), .jumpTarget(jumpTarget),
		.newStackPointer(newSp), .busy(busy));
	aes_mem_model mem (.clk(clk), .waitCycles(waitCycles), .busReq(busReq), .busRsp(busRsp));
	task automatic endSim();
		if (errCount == 0 && samplesChecked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// error held high past the take tests that a busy sequencer ignores it
	task automatic runSeq(input logic [3:0] w, input logic [31:0] sp);
		int n, early, aborts, stalled;
		logic drainBusy;
		waitCycles = w;
		cpuState = '{32'h0000_00f1, 32'h0000_0402, sp, 32'h0000_1000};
		addrError = 1'b1;
		early = 0;
		aborts = 0;
		stalled = 0;
		drainBusy = 1'b0;
		for (n = 0; n < 200 && jumpValid !== 1'b1; n++) begin
			@(negedge clk);
			if ((busReq.req || stallPipe) && n < 7) early++;
			if (abortCycle === 1'b1) aborts++;
			if (stallPipe === 1'b1) stalled = 1;
			if (n == 6) drainBusy = busy;
			if (n == 4) addrError = 1'b0;
			instrDone = (n == 6);
		end
		`CHK("early", 0, early)
		`CHK("abort", 1, aborts)
		`CHK("drainBusy", 1'b1, drainBusy)
		`CHK("stall", 1, stalled)
		`CHK("jump", 1'b1, jumpValid)
		if (jumpValid !== 1'b1) endSim();
		`CHK("target", 32'h0000_1230, jumpTarget)
		`CHK("kill", 1'b1, killDelaySlot)
		`CHK("srAddr", sp - 32'h4, mem.wa[0])
		`CHK("srData", 32'h0000_00f1, mem.wd[0])
		`CHK("pcAddr", sp - 32'h8, mem.wa[1])
		`CHK("pcData", 32'h0000_0402, mem.wd[1])
		`CHK("sp", sp - 32'h8, newSp)
		repeat (3) @(negedge clk);
		`CHK("idle", 1'b0, busy)
		`CHK("release", 1'b0, stallPipe)
	endtask
	// reset in mid-push must drop the bus request at once and leave the unit idle
	task automatic midReset();
		int n;
		waitCycles = 4'h3;
		addrError = 1'b1;
		for (n = 0; n < 20 && busReq.req !== 1'b1; n++) begin
			@(negedge clk);
			addrError = 1'b0;
			instrDone = (n == 2);
		end
		`CHK("reqBefore", 1'b1, busReq.req)
		arst_n = 1'b0;
		#1;
		`CHK("rstReq", 1'b0, busReq.req)
		`CHK("rstBusy", 1'b0, busy)
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{arst_n, addrError, instrDone, waitCycles, cpuState} = '0;
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
		runSeq(4'h0, 32'h0000_2000);
		runSeq(4'h3, 32'h0000_3ff0);
		midReset();
		runSeq(4'h1, 32'h0000_1004);
		endSim();
	end
endmodule // aes_seq_tb_top
`default_nettype wire

// file: core/aes_bus_step.sv
`timescale 1ns/1ps
`default_nettype none
`include "aes_params.svh"
// one bus transaction: holds request until ack, pulses done with read data
module aes_bus_step (
	input  wire logic             clk,
	input  wire logic             rstN,
	input  wire logic             start,
	input  wire logic             wr,
	input  wire logic [31:0]      addr,
	input  wire logic [31:0]      wdata,
	input  wire aes_pkg::aes_bus_rsp_type rsp,
	output var  aes_pkg::aes_bus_req_type req,
	output logic                  done,
	output logic [31:0]           rdata
);
	import aes_pkg::*;
	aes_bus_req_type req_q;
	logic            done_q;
	logic [31:0]     rdata_q;
	wire             finish = req_q.req && rsp.ack;
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			req_q   <= '0;
			done_q  <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			done_q <= finish;
			if (finish) begin
				req_q.req <= 1'b0;
				rdata_q   <= rsp.rdata;
			end else if (start && !req_q.req) begin
				req_q <= '{req: 1'b1, write: wr, addr: addr, wdata: wdata};
			end
		end
	end
	assign req   = req_q;
	assign done  = done_q;
	assign rdata = rdata_q;
endmodule // aes_bus_step
`default_nettype wire

// file: core/aes_params.svh
`ifndef AES_PARAMS_SVH
`define AES_PARAMS_SVH
`define AES_WORD_BYTES      32'h0000_0004
`define AES_VEC_ADDR_ERR    32'h0000_0024
`define AES_VBR_RESET       32'h0000_0000
`define AES_BUS_TIMEOUT     16'h0100
`endif

// file: core/aes_pkg.sv
package aes_pkg;
	typedef struct packed {
		logic        req;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} aes_bus_req_type;
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} aes_bus_rsp_type;
	typedef struct packed {
		logic [31:0] statusWord;
		logic [31:0] nextPointer;
		logic [31:0] stackPointer;
		logic [31:0] vectorBase;
	} aes_cpu_state_type;
endpackage

// file: core/aes_seq.sv
// How it works
// RQ1: address error ends the faulting bus cycle
// RQ2: wait for current instruction to finish
// RQ3: push status word first
// RQ4: push return address second
// RQ5: fetch handler vector, jump there
// RQ6: jump immediately, no delay slot
// RQ7: predecrement stack by four, longword writes
`timescale 1ns/1ps
`default_nettype none
`include "aes_params.svh"
module aes_seq (
	input  wire logic                       clk,
	input  wire logic                       arst_n,
	input  wire logic                       addrError,
	input  wire logic                       instrDone,
	input  wire aes_pkg::aes_cpu_state_type cpuState,
	input  wire aes_pkg::aes_bus_rsp_type   busRsp,
	output var  aes_pkg::aes_bus_req_type   busReq,
	output logic                            abortCycle,
	output logic                            stallPipe,
	output logic                            jumpValid,
	output logic                            killDelaySlot,
	output logic [31:0]                     jumpTarget,
	output logic [31:0]                     newStackPointer,
	output logic                            busy
);
	import aes_pkg::*;
	typedef enum logic [2:0] {IDLE, DRAIN, PUSH_SR, PUSH_PC, FETCH, JUMP} aes_state_type;

	// two-stage release; assertion of reset stays asynchronous
	logic rsync1_q, rsync2_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rsync1_q <= 1'b0;
		end else begin
			rsync1_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rsync2_q <= 1'b0;
		end else begin
			rsync2_q <= rsync1_q;
		end
	end
	wire rstN = rsync2_q;

	// each push lands one longword below the pointer it starts from
	function automatic logic [31:0] preDec(input logic [31:0] sp);
		preDec = sp - `AES_WORD_BYTES;
	endfunction

	aes_state_type   state_q, state_d;
	logic [31:0]     sp_q, sp_d;
	logic [31:0]     ret_q, sr_q, vbr_q, tgt_q;
	logic            abort_q, jump_q, kill_q;
	logic            stall_q, busy_q;
	logic            stepStart, stepWr, stepDone;
	logic [31:0]     stepAddr, stepWdata, stepRdata;

	// state decodes, shared by the bus step and the output flops
	wire inIdle    = (state_q == IDLE);
	wire inDrain   = (state_q == DRAIN);
	wire inPushSr  = (state_q == PUSH_SR);
	wire inPushPc  = (state_q == PUSH_PC);
	wire inFetch   = (state_q == FETCH);
	wire inPush    = inPushSr || inPushPc;
	wire takeErr   = inIdle && addrError;
	wire drainEnd  = inDrain && instrDone;
	wire srDone    = inPushSr && stepDone;
	wire fetchDone = inFetch && stepDone;
	wire nextBusy  = (state_d != IDLE);
	wire nextStall = nextBusy && (state_d != DRAIN);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			IDLE: begin
				if (addrError) state_d = DRAIN; // RQ1
			end
			DRAIN: begin
				if (instrDone) state_d = PUSH_SR; // RQ2
			end
			PUSH_SR: begin
				if (stepDone) state_d = PUSH_PC; // RQ3
			end
			PUSH_PC: begin
				if (stepDone) state_d = FETCH; // RQ4
			end
			FETCH: begin
				if (stepDone) state_d = JUMP; // RQ5
			end
			JUMP: begin
				state_d = IDLE; // RQ6
			end
		endcase
	end

	// pointer snapshot only once the instruction has retired
	assign sp_d = drainEnd ? preDec(cpuState.stackPointer) : // RQ7
		(srDone ? preDec(sp_q) : sp_q); // RQ7

	assign stepStart = (inPush || inFetch) && !stepDone;
	assign stepWr    = inPush;
	assign stepAddr  = inFetch ? (vbr_q + `AES_VEC_ADDR_ERR) : sp_q; // RQ5 RQ7
	assign stepWdata = inPushSr ? sr_q : ret_q; // RQ3 RQ4

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_q <= IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			sp_q <= '0;
		end else begin
			sp_q <= sp_d; // RQ7
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			sr_q <= '0;
		end else if (drainEnd) begin
			sr_q <= cpuState.statusWord; // RQ3
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			ret_q <= '0;
		end else if (drainEnd) begin
			ret_q <= cpuState.nextPointer; // RQ4
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			vbr_q <= `AES_VBR_RESET;
		end else if (drainEnd) begin
			vbr_q <= cpuState.vectorBase; // RQ5
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			tgt_q <= '0;
		end else if (fetchDone) begin
			tgt_q <= stepRdata; // RQ5
		end
	end

	// abort lags the error by one edge; the bus side ends the cycle on it
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			abort_q <= 1'b0;
		end else begin
			abort_q <= takeErr; // RQ1
		end
	end

	// jump and slot kill share one edge, so no delay slot ever issues
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			jump_q <= 1'b0;
		end else begin
			jump_q <= fetchDone; // RQ6
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			kill_q <= 1'b0;
		end else begin
			kill_q <= fetchDone; // RQ6
		end
	end

	// stall follows the next state so it is up before the first push starts
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			stall_q <= 1'b0;
		end else begin
			stall_q <= nextStall;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= nextBusy;
		end
	end

	aes_bus_step uStep (
		.clk   (clk),
		.rstN  (rstN),
		.start (stepStart),
		.wr    (stepWr),
		.addr  (stepAddr),
		.wdata (stepWdata),
		.rsp   (busRsp),
		.req   (busReq),
		.done  (stepDone),
		.rdata (stepRdata)
	);

	assign abortCycle      = abort_q;
	assign stallPipe       = stall_q;
	assign jumpValid       = jump_q;
	assign killDelaySlot   = kill_q;
	assign jumpTarget      = tgt_q;
	assign newStackPointer = sp_q;
	assign busy            = busy_q;
endmodule // aes_seq
`default_nettype wire
